// ### logic/lla_pkg.sv
// Constants and types for the front-panel lamp annunciator
package lla_pkg;

	// Timing
	localparam int CLK_KHZ = 10000;
	localparam int BLINK_HALF_MS = 250;
	localparam int BLINK_HALF_CYC = BLINK_HALF_MS * CLK_KHZ;
	localparam int BLINK_W = 22;

	// Lamp positions
	localparam int LAMPS = 8;
	localparam int L_THERMAL = 0;
	localparam int L_PHASE = 1;
	localparam int L_I2T = 2;
	localparam int L_EARTH = 3;
	localparam int L_PROGFAULT = 4;
	localparam int L_BLOCK = 5;
	localparam int L_BRKFAIL = 6;
	localparam int L_UNBALANCE = 7;
	localparam logic [7:0] LATCH_MASK = 8'hCF;

	// Register offsets
	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_STATUS = 8'h04;
	localparam logic [7:0] A_DISP_LO = 8'h08;
	localparam logic [7:0] A_DISP_HI = 8'h0C;

	// Field positions
	localparam int CTRL_RESET_BIT = 0;
	localparam int STAT_LATCH_LSB = 0;
	localparam int STAT_FLASH_LSB = 8;
	localparam int STAT_LAMP_LSB = 16;

	// Reset values
	localparam logic [63:0] DISP_RST = 64'h2020202020202020;

	// Flags from the protection elements
	typedef struct packed {
		logic thermalAlarmReached;
		logic oilImage125;
		logic windingImage200;
		logic phaseLowPickup;
		logic phaseHighPickup;
		logic phaseLowDelayDone;
		logic phaseHighDelayDone;
		logic i2tOverBase;
		logic i2tLimitReached;
		logic earthLowPickup;
		logic earthHighPickup;
		logic earthLowDelayDone;
		logic earthHighDelayDone;
		logic programming;
		logic internalFault;
		logic [1:0] blockInput;
		logic remoteTripInput;
		logic breakerFailActive;
		logic unbalanceFirstPickup;
		logic unbalanceSecondPickup;
		logic unbalanceFirstDelayDone;
		logic unbalanceSecondDelayDone;
	} lla_flags_t;

	// Whole state of the annunciator
	typedef struct packed {
		logic [7:0] latch;
		logic [7:0] lamp;
		logic [BLINK_W-1:0] blinkCnt;
		logic blinkOn;
		logic failSeen;
		logic nvWrite;
		logic [7:0] nvOut;
		logic pready;
		logic [31:0] prdata;
		logic pslverr;
		logic keyPend;
		logic [63:0] disp;
	} lla_state_t;

	localparam lla_state_t STATE_RST = '{
		latch: 8'h00,
		lamp: 8'h00,
		blinkCnt: 22'h0,
		blinkOn: 1'b0,
		failSeen: 1'b0,
		nvWrite: 1'b0,
		nvOut: 8'h00,
		pready: 1'b0,
		prdata: 32'h0,
		pslverr: 1'b0,
		keyPend: 1'b0,
		disp: DISP_RST
	};

endpackage

// ### logic/lla_annunciator.sv
// Lamp annunciator with latching, flashing, retention and APB registers
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// RULE_01: Eight lamps, all off while no indicated condition is present.
// RULE_02: An eight-character display shows readings written by software.
// RULE_03: Thermal lamp flashes when the thermal image reaches alarm level.
// RULE_04: Thermal lamp steady at oil image 125% or winding image 200%.
// RULE_05: Phase lamp flashes while low or high pickup is reached.
// RULE_06: Phase lamp steady once low or high stage delay has expired.
// RULE_07: I2t lamp flashes above twice base current, steady at the I2t limit.
// RULE_08: Earth lamp flashes while low or high earth pickup is reached.
// RULE_09: Earth lamp steady once low or high earth delay has expired.
// RULE_10: Program/fault lamp flashes while programming or on internal fault.
// RULE_11: Block lamp flashes while any blocking input is active.
// RULE_12: Block lamp steady while the remote trip input is operated.
// RULE_13: Breaker failure lamp lit when breaker failure function is active.
// RULE_14: Unbalance lamp flashes while first or second pickup is reached.
// RULE_15: Unbalance lamp steady once first or second delay has expired.
// RULE_16: Flashing on the six latching lamps ends by itself with its cause.
// RULE_17: Steady on those six stays latched; reset key clears it once cause gone.
// RULE_18: Program/fault and block lamps never latch; steady ends with cause.
// RULE_19: Lamp latches are saved on supply loss and restored on return.
// RULE_20: The front enter/reset key acts as the lamp reset command.
// RULE_21: Flashing comes from a fixed clock division, a few hertz.
// RULE_22: A lamp qualifying for both flashing and steady shows steady.
module lla_annunciator #(
	parameter int BLINK_HALF = lla_pkg::BLINK_HALF_CYC
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Protection element flags
	input wire lla_pkg::lla_flags_t flags,
	// Front enter/reset key, one-cycle pulse
	input wire logic keyReset,
	// Retention store
	input wire logic supplyFail,
	input wire logic restoreReq,
	input wire logic [7:0] nvIn,
	output logic nvWrite,
	output logic [7:0] nvOut,
	// Front panel
	output logic [7:0] lampOn,
	output logic [63:0] dispChars
);

	lla_pkg::lla_state_t s_r;
	lla_pkg::lla_state_t s_nxt;
	logic [7:0] flash;
	logic [7:0] trip;
	logic [7:0] lampV;
	logic press;
	logic setup;
	logic access;
	logic [31:0] rdVal;
	logic rdHit;

	// Flashing causes per lamp
	assign flash[lla_pkg::L_THERMAL] = flags.thermalAlarmReached; // [RULE_03]
	assign flash[lla_pkg::L_PHASE] = flags.phaseLowPickup | flags.phaseHighPickup; // [RULE_05]
	assign flash[lla_pkg::L_I2T] = flags.i2tOverBase; // [RULE_07]
	assign flash[lla_pkg::L_EARTH] = flags.earthLowPickup | flags.earthHighPickup; // [RULE_08]
	assign flash[lla_pkg::L_PROGFAULT] = flags.programming | flags.internalFault; // [RULE_10]
	assign flash[lla_pkg::L_BLOCK] = |flags.blockInput; // [RULE_11]
	assign flash[lla_pkg::L_BRKFAIL] = 1'b0;
	assign flash[lla_pkg::L_UNBALANCE] = flags.unbalanceFirstPickup | flags.unbalanceSecondPickup; // [RULE_14]

	// Steady causes per lamp
	assign trip[lla_pkg::L_THERMAL] = flags.oilImage125 | flags.windingImage200; // [RULE_04]
	assign trip[lla_pkg::L_PHASE] = flags.phaseLowDelayDone | flags.phaseHighDelayDone; // [RULE_06]
	assign trip[lla_pkg::L_I2T] = flags.i2tLimitReached; // [RULE_07]
	assign trip[lla_pkg::L_EARTH] = flags.earthLowDelayDone | flags.earthHighDelayDone; // [RULE_09]
	assign trip[lla_pkg::L_PROGFAULT] = 1'b0;
	assign trip[lla_pkg::L_BLOCK] = flags.remoteTripInput; // [RULE_12]
	assign trip[lla_pkg::L_BRKFAIL] = flags.breakerFailActive; // [RULE_13]
	assign trip[lla_pkg::L_UNBALANCE] = flags.unbalanceFirstDelayDone | flags.unbalanceSecondDelayDone; // [RULE_15]

	// Reset command from key or register
	assign press = keyReset | s_r.keyPend; // [RULE_20]

	// Per-lamp display state, steady over flashing
	genvar gi;
	generate
		for (gi = 0; gi < lla_pkg::LAMPS; gi++) begin : g_lamp
			assign lampV[gi] = s_r.latch[gi] | trip[gi] | (flash[gi] & s_r.blinkOn); // [RULE_01] [RULE_16] [RULE_22]
		end
	endgenerate

	// APB phases
	assign setup = psel & ~penable;
	assign access = psel & penable & s_r.pready;

	// Read decode
	always_comb begin
		rdVal = 32'h0;
		rdHit = 1'b1;
		unique case (paddr)
			lla_pkg::A_CTRL: begin
				rdVal = 32'h0;
			end
			lla_pkg::A_STATUS: begin
				rdVal[lla_pkg::STAT_LATCH_LSB +: 8] = s_r.latch;
				rdVal[lla_pkg::STAT_FLASH_LSB +: 8] = flash;
				rdVal[lla_pkg::STAT_LAMP_LSB +: 8] = s_r.lamp;
			end
			lla_pkg::A_DISP_LO: begin
				rdVal = s_r.disp[31:0];
			end
			lla_pkg::A_DISP_HI: begin
				rdVal = s_r.disp[63:32];
			end
			default: begin
				rdHit = 1'b0;
			end
		endcase
	end

	// Next state
	always_comb begin
		s_nxt = s_r;
		s_nxt.keyPend = 1'b0;
		s_nxt.nvWrite = 1'b0;
		s_nxt.failSeen = supplyFail;
		// Blink divider
		if (s_r.blinkCnt == lla_pkg::BLINK_W'(BLINK_HALF - 1)) begin
			s_nxt.blinkCnt = 22'h0; // [RULE_21]
			s_nxt.blinkOn = ~s_r.blinkOn;
		end else begin
			s_nxt.blinkCnt = s_r.blinkCnt + 22'h1;
		end
		// Latches: restore, reset press, or accumulate
		if (restoreReq) begin
			s_nxt.latch = (nvIn | trip) & lla_pkg::LATCH_MASK; // [RULE_19]
		end else if (press) begin
			s_nxt.latch = trip & lla_pkg::LATCH_MASK; // [RULE_17]
		end else begin
			s_nxt.latch = (s_r.latch | trip) & lla_pkg::LATCH_MASK; // [RULE_17] [RULE_18]
		end
		s_nxt.lamp = lampV;
		// Save on supply loss
		if (supplyFail && !s_r.failSeen) begin
			s_nxt.nvWrite = 1'b1; // [RULE_19]
			s_nxt.nvOut = s_r.latch;
		end
		// APB answer in the first access cycle
		s_nxt.pready = setup;
		if (setup) begin
			s_nxt.pslverr = ~rdHit;
			s_nxt.prdata = (pwrite || !rdHit) ? 32'h0 : rdVal;
		end
		// APB writes
		if (access && pwrite) begin
			unique case (paddr)
				lla_pkg::A_CTRL: begin
					s_nxt.keyPend = pwdata[lla_pkg::CTRL_RESET_BIT]; // [RULE_20]
				end
				lla_pkg::A_DISP_LO: begin
					s_nxt.disp[31:0] = pwdata; // [RULE_02]
				end
				lla_pkg::A_DISP_HI: begin
					s_nxt.disp[63:32] = pwdata; // [RULE_02]
				end
				default: begin
					s_nxt.keyPend = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			s_r <= lla_pkg::STATE_RST;
		end else begin
			s_r <= s_nxt;
		end
	end

	// Outputs
	assign prdata = s_r.prdata;
	assign pready = s_r.pready;
	assign pslverr = s_r.pslverr;
	assign nvWrite = s_r.nvWrite;
	assign nvOut = s_r.nvOut;
	assign lampOn = s_r.lamp;
	assign dispChars = s_r.disp;

	// Checks
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_b);

	AST_QUIET_OFF: assert property ( // [RULE_01]
		(flash == 8'h00 && trip == 8'h00 && s_r.latch == 8'h00) |=> (lampOn == 8'h00)
	) else $error("lamp lit with no cause");

	AST_THERMAL_STEADY: assert property ( // [RULE_04]
		(flags.oilImage125 || flags.windingImage200) |=> lampOn[lla_pkg::L_THERMAL]
	) else $error("thermal lamp not steady on trip");

	AST_PHASE_LATCH: assert property ( // [RULE_06]
		(trip[lla_pkg::L_PHASE] && !press && !restoreReq) |=> s_r.latch[lla_pkg::L_PHASE]
			##1 (lampOn[lla_pkg::L_PHASE] || $past(press) || $past(restoreReq))
	) else $error("phase trip not latched");

	AST_LATCH_HOLD: assert property ( // [RULE_17]
		(s_r.latch[lla_pkg::L_EARTH] && !press && !restoreReq)
			|=> s_r.latch[lla_pkg::L_EARTH] ##1 (lampOn[lla_pkg::L_EARTH] || $past(press) || $past(restoreReq))
	) else $error("earth latch lost without reset");

	AST_LATCH_CLEAR: assert property ( // [RULE_17]
		(s_r.latch[lla_pkg::L_UNBALANCE] && press && !restoreReq && !trip[lla_pkg::L_UNBALANCE])
			|=> !s_r.latch[lla_pkg::L_UNBALANCE]
	) else $error("reset did not clear unbalance latch");

	AST_NO_LATCH: assert property ( // [RULE_18]
		(!flags.remoteTripInput && flags.blockInput == 2'b00) |=> !lampOn[lla_pkg::L_BLOCK] && !s_r.latch[lla_pkg::L_BLOCK]
	) else $error("block lamp latched");

	AST_FLASH_ENDS: assert property ( // [RULE_16]
		(!flash[lla_pkg::L_I2T] && !trip[lla_pkg::L_I2T] && !s_r.latch[lla_pkg::L_I2T])
			|=> !lampOn[lla_pkg::L_I2T]
	) else $error("i2t flash did not end");

	AST_STEADY_WINS: assert property ( // [RULE_22]
		(flash[lla_pkg::L_UNBALANCE] && trip[lla_pkg::L_UNBALANCE]) |=> lampOn[lla_pkg::L_UNBALANCE]
	) else $error("flash overrode steady");

	AST_FLASH_FOLLOWS_BLINK: assert property ( // [RULE_10]
		(flash[lla_pkg::L_PROGFAULT] && !flags.remoteTripInput)
			|=> (lampOn[lla_pkg::L_PROGFAULT] == $past(s_r.blinkOn))
	) else $error("program lamp not following blink");

	AST_BLINK_SLOW: assert property ( // [RULE_21]
		$changed(s_r.blinkOn) |=> $stable(s_r.blinkOn) [*2]
	) else $error("blink toggles too fast");

	AST_SAVE: assert property ( // [RULE_19]
		$rose(supplyFail) |=> (nvWrite && nvOut == $past(s_r.latch)) ##1 !nvWrite
	) else $error("latch image not saved");

	AST_RESTORE: assert property ( // [RULE_19]
		restoreReq |=> (s_r.latch == (($past(nvIn) | $past(trip)) & lla_pkg::LATCH_MASK))
	) else $error("latch image not restored");

	AST_DISP_WRITE: assert property ( // [RULE_02]
		(access && pwrite && paddr == lla_pkg::A_DISP_LO) |=> (dispChars[31:0] == $past(pwdata))
	) else $error("display word not written");

	AST_APB_READY: assert property (
		setup |=> pready ##1 !pready
	) else $error("apb answer not in first access cycle");

	AST_THERMAL_FLASH: assert property ( // [RULE_03]
		(flags.thermalAlarmReached && !trip[lla_pkg::L_THERMAL] && !s_r.latch[lla_pkg::L_THERMAL])
			|=> (lampOn[lla_pkg::L_THERMAL] == $past(s_r.blinkOn))
	) else $error("thermal lamp not flashing");

	AST_PHASE_FLASH: assert property ( // [RULE_05]
		(flash[lla_pkg::L_PHASE] && !trip[lla_pkg::L_PHASE] && !s_r.latch[lla_pkg::L_PHASE])
			|=> (lampOn[lla_pkg::L_PHASE] == $past(s_r.blinkOn))
	) else $error("phase lamp not flashing");

	AST_I2T_FLASH: assert property ( // [RULE_07]
		(flags.i2tOverBase && !trip[lla_pkg::L_I2T] && !s_r.latch[lla_pkg::L_I2T])
			|=> (lampOn[lla_pkg::L_I2T] == $past(s_r.blinkOn))
	) else $error("i2t lamp not flashing");

	AST_I2T_STEADY: assert property ( // [RULE_07]
		flags.i2tLimitReached
			|=> (lampOn[lla_pkg::L_I2T] && s_r.latch[lla_pkg::L_I2T])
	) else $error("i2t lamp not steady at limit");

	AST_EARTH_FLASH: assert property ( // [RULE_08]
		(flash[lla_pkg::L_EARTH] && !trip[lla_pkg::L_EARTH] && !s_r.latch[lla_pkg::L_EARTH])
			|=> (lampOn[lla_pkg::L_EARTH] == $past(s_r.blinkOn))
	) else $error("earth lamp not flashing");

	AST_EARTH_STEADY: assert property ( // [RULE_09]
		(flags.earthLowDelayDone || flags.earthHighDelayDone)
			|=> (lampOn[lla_pkg::L_EARTH] && s_r.latch[lla_pkg::L_EARTH])
	) else $error("earth lamp not steady on trip");

	AST_BLOCK_FLASH: assert property ( // [RULE_11]
		(flash[lla_pkg::L_BLOCK] && !flags.remoteTripInput)
			|=> (lampOn[lla_pkg::L_BLOCK] == $past(s_r.blinkOn))
	) else $error("block lamp not flashing");

	AST_BLOCK_STEADY: assert property ( // [RULE_12]
		flags.remoteTripInput
			|=> lampOn[lla_pkg::L_BLOCK]
	) else $error("block lamp not steady on remote trip");

	AST_BRKFAIL_LIT: assert property ( // [RULE_13]
		flags.breakerFailActive
			|=> (lampOn[lla_pkg::L_BRKFAIL] && s_r.latch[lla_pkg::L_BRKFAIL])
	) else $error("breaker failure lamp not lit");

	AST_UNBAL_FLASH: assert property ( // [RULE_14]
		(flash[lla_pkg::L_UNBALANCE] && !trip[lla_pkg::L_UNBALANCE] && !s_r.latch[lla_pkg::L_UNBALANCE])
			|=> (lampOn[lla_pkg::L_UNBALANCE] == $past(s_r.blinkOn))
	) else $error("unbalance lamp not flashing");

	AST_UNBAL_STEADY: assert property ( // [RULE_15]
		(flags.unbalanceFirstDelayDone || flags.unbalanceSecondDelayDone)
			|=> (lampOn[lla_pkg::L_UNBALANCE] && s_r.latch[lla_pkg::L_UNBALANCE])
	) else $error("unbalance lamp not steady on trip");

	AST_PROG_UNLATCHED: assert property ( // [RULE_18]
		(!flags.programming && !flags.internalFault)
			|=> !lampOn[lla_pkg::L_PROGFAULT]
	) else $error("program lamp stayed lit");

	AST_SET_WINS: assert property ( // [RULE_17]
		(press && trip[lla_pkg::L_PHASE])
			|=> s_r.latch[lla_pkg::L_PHASE]
	) else $error("reset cleared latch with cause present");

	AST_KEY_CLEAR: assert property ( // [RULE_20]
		(keyReset && !restoreReq)
			|=> (s_r.latch == ($past(trip) & lla_pkg::LATCH_MASK))
	) else $error("front key did not reset latches");

	AST_BLINK_EDGE: assert property ( // [RULE_21]
		(s_r.blinkCnt == lla_pkg::BLINK_W'(BLINK_HALF - 1))
			|=> ($changed(s_r.blinkOn) && s_r.blinkCnt == 22'h0)
	) else $error("blink phase did not toggle");

	AST_BLINK_HOLD: assert property ( // [RULE_21]
		(s_r.blinkCnt != lla_pkg::BLINK_W'(BLINK_HALF - 1))
			|=> $stable(s_r.blinkOn)
	) else $error("blink phase toggled early");

	AST_DISP_HI_WRITE: assert property ( // [RULE_02]
		(access && pwrite && paddr == lla_pkg::A_DISP_HI)
			|=> (dispChars[63:32] == $past(pwdata))
	) else $error("upper display word not written");

endmodule

`default_nettype wire

// ### dv/lla_elements.sv
// Model of the protection element flags and the front key
`timescale 1ns/1ps
`default_nettype none
module lla_elements (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Commands from the bench
	input wire lla_pkg::lla_flags_t want,
	input wire logic slow,
	input wire logic pressKey,
	// Towards the annunciator
	output lla_pkg::lla_flags_t flags,
	output logic keyReset
);
	lla_pkg::lla_flags_t stage;
	logic keyLast;
	// Slow mode adds one cycle of element latency
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			stage <= '0;
			flags <= '0;
			keyLast <= 1'b0;
			keyReset <= 1'b0;
		end else begin
			stage <= want;
			flags <= slow ? stage : want;
			keyLast <= pressKey;
			keyReset <= pressKey & ~keyLast;
		end
	end
endmodule
`default_nettype wire

// ### dv/led_annunciator_latch_tb.sv
// Self-checking bench for the lamp annunciator
`timescale 1ns/1ps
`default_nettype none
module led_annunciator_latch_tb;
	localparam int BH = 4;
	logic clk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic slow = 1'b0, pressKey = 1'b0, supplyFail = 1'b0, restoreReq = 1'b0, look = 1'b0;
	logic [7:0] paddr = 8'h00, nvIn = 8'h00, mask = 8'h00, hist = 8'h00, img, nvOut, lampOn;
	logic [31:0] pwdata = 32'h0, prdata, rnd;
	logic pready, pslverr, nvWrite, keyReset;
	logic [63:0] dispChars, got, e;
	lla_pkg::lla_flags_t want = '0, flags;
	int fails = 0, samples_checked = 0, seed = 32'hbb31, cycles = 0, sel;
	int selQ[$];
	logic [63:0] expQ[$];
	int sBit[11] = '{21, 20, 17, 16, 14, 11, 10, 5, 4, 1, 0};
	int sLamp[11] = '{0, 0, 1, 1, 2, 3, 3, 5, 6, 7, 7};
	int fBit[12] = '{22, 19, 18, 15, 13, 12, 9, 8, 7, 6, 3, 2};
	int fLamp[12] = '{0, 1, 1, 2, 3, 3, 4, 4, 5, 5, 7, 7};

	always #50 clk = ~clk;

	lla_annunciator #(.BLINK_HALF(BH)) u_lla_annunciator (.clk(clk), .rst_b(rst_b), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .flags(flags), .keyReset(keyReset),
		.supplyFail(supplyFail), .restoreReq(restoreReq), .nvIn(nvIn), .nvWrite(nvWrite),
		.nvOut(nvOut), .lampOn(lampOn), .dispChars(dispChars));
	lla_elements u_lla_elements (.clk(clk), .rst_b(rst_b), .want(want), .slow(slow),
		.pressKey(pressKey), .flags(flags), .keyReset(keyReset));

	task wrap_up;
		$display("Checks %0d, mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask

	// Result watcher: oldest note against what the outputs show
	always @(posedge clk) begin
		hist <= {hist[6:0], |(lampOn & mask)};
		cycles = cycles + 1;
		if (cycles == 5000) begin
			fails++;
			wrap_up();
		end
		if ((psel && penable && pready) || look) begin
			sel = selQ.pop_front();
			e = expQ.pop_front();
			case (sel)
				0: got = {31'h0, pslverr, prdata};
				1: got = {56'h0, lampOn};
				2: got = {55'h0, nvWrite, nvOut};
				3: got = dispChars;
				default: got = 64'($countones(hist));
			endcase
			samples_checked++;
			if (got !== e) begin
				fails++;
				$display("Error at %0t: expected %h got %h", $time, e, got);
			end
		end
	end

	task cyc(input int n);
		repeat (n) @(posedge clk);
	endtask
	task note(input int s, input logic [63:0] v);
		selQ.push_back(s);
		expQ.push_back(v);
	endtask
	task probe(input int s, input logic [63:0] v);
		note(s, v);
		look <= 1'b1;
		@(posedge clk);
		look <= 1'b0;
		@(posedge clk);
	endtask
	task press;
		pressKey <= 1'b1;
		@(posedge clk);
		pressKey <= 1'b0;
		cyc(3);
	endtask
	task apb(input int w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] v);
		note(0, {31'h0, v});
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w[0];
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	initial begin
		cyc(10);
		rst_b <= 1'b1;
		cyc(2);
		probe(1, 64'h0);
		probe(3, lla_pkg::DISP_RST);
		apb(0, lla_pkg::A_STATUS, 32'h0, 33'h0);
		apb(0, lla_pkg::A_CTRL, 32'h0, 33'h0);
		repeat (2) begin
			rnd = $random(seed);
			apb(1, lla_pkg::A_DISP_LO, rnd, 33'h0);
			apb(1, lla_pkg::A_DISP_HI, ~rnd, 33'h0);
			apb(0, lla_pkg::A_DISP_LO, 32'h0, {1'b0, rnd});
			apb(0, lla_pkg::A_DISP_HI, 32'h0, {1'b0, ~rnd});
			probe(3, {~rnd, rnd});
		end
		apb(1, 8'h10, rnd, 33'h100000000);
		apb(0, 8'h10, 32'h0, 33'h100000000);
		apb(1, lla_pkg::A_STATUS, rnd, 33'h0);
		$display("register test done");
		for (int i = 0; i < 11; i++) begin
			slow <= i[0];
			want <= lla_pkg::lla_flags_t'(23'h1 << sBit[i]);
			cyc(3);
			probe(1, 64'h1 << sLamp[i]);
			press();
			want <= '0;
			cyc(3);
			probe(1, sLamp[i] == 5 ? 64'h0 : 64'h1 << sLamp[i]);
			press();
			probe(1, 64'h0);
		end
		$display("steady test done");
		for (int i = 0; i < 12; i++) begin
			mask <= 8'h1 << fLamp[i];
			want <= lla_pkg::lla_flags_t'(23'h1 << fBit[i]);
			cyc(12);
			probe(4, 64'(BH));
			want <= '0;
			cyc(3);
			probe(1, 64'h0);
		end
		mask <= 8'h02;
		want <= 23'h0A0000;
		cyc(12);
		probe(4, 64'h8);
		want <= '0;
		press();
		probe(1, 64'h0);
		$display("flash test done");
		want <= 23'h020010;
		cyc(3);
		want <= '0;
		cyc(3);
		supplyFail <= 1'b1;
		@(posedge clk);
		probe(2, 64'h142);
		supplyFail <= 1'b0;
		apb(1, lla_pkg::A_CTRL, 32'h1, 33'h0);
		cyc(2);
		probe(1, 64'h0);
		rnd = $random(seed);
		img = rnd[7:0] & lla_pkg::LATCH_MASK;
		nvIn <= rnd[7:0];
		restoreReq <= 1'b1;
		@(posedge clk);
		restoreReq <= 1'b0;
		cyc(3);
		probe(1, {56'h0, img});
		apb(0, lla_pkg::A_STATUS, 32'h0, {9'h0, img, 8'h00, img});
		apb(1, lla_pkg::A_CTRL, 32'h1, 33'h0);
		cyc(2);
		probe(1, 64'h0);
		$display("retention test done");
		wrap_up();
	end
endmodule
`default_nettype wire
